// *** inc/tspc_defines.vh ***
// register indices, reset values and bus codes of the timer/serial pin control block
`ifndef TSPC_DEFINES_VH
`define TSPC_DEFINES_VH

// register indices; the byte address on the bus is four times the index
`define TSPC_IDX_TPORT_OUTPUT_VALUE   6'h00
`define TSPC_IDX_TPORT_PIN_READBACK   6'h01
`define TSPC_IDX_TPORT_DIRECTION      6'h02
`define TSPC_IDX_TPORT_DRIVE_STRENGTH 6'h03
`define TSPC_IDX_TPORT_PULL_ENABLE    6'h04
`define TSPC_IDX_TPORT_PULL_POLARITY  6'h05
`define TSPC_IDX_SPORT_OUTPUT_VALUE   6'h08
`define TSPC_IDX_SPORT_PIN_READBACK   6'h09
`define TSPC_IDX_SPORT_DIRECTION      6'h0A
`define TSPC_IDX_SPORT_DRIVE_STRENGTH 6'h0B
`define TSPC_IDX_SPORT_PULL_ENABLE    6'h0C
`define TSPC_IDX_SPORT_PULL_POLARITY  6'h0D
`define TSPC_IDX_SPORT_OPEN_DRAIN     6'h0E
`define TSPC_IDX_IRQ_STATUS           6'h10
`define TSPC_IDX_IRQ_MASK             6'h11

// reset values
`define TSPC_RST_ZERO8        8'h00
`define TSPC_RST_SPORT_PULLEN 8'hFF
`define TSPC_RST_IRQ          2'h0

// interrupt status bit positions
`define TSPC_IRQ_TPORT_BIT 0
`define TSPC_IRQ_SPORT_BIT 1

// address slice that selects the register index
`define TSPC_IDX_MSB 7
`define TSPC_IDX_LSB 2

// response codes
`define TSPC_RESP_OKAY   2'h0
`define TSPC_RESP_SLVERR 2'h2

`endif

// *** design/tspc_pin_port.v ***
// one port of pin drivers, pull control, pin synchronisers and edge events
`timescale 1ns/100ps
module tspc_pin_port #(
   parameter W = 8,
   parameter HAS_IE = 0
) (
   input wire clk_i,               // bus clock
   input wire rst_n_i,             // synchronous reset, active low
   input wire ce_i,                // clock enable
   input wire [W-1:0] dir_i,       // effective direction, 1 = output
   input wire [W-1:0] val_i,       // effective output value
   input wire [W-1:0] rdr_i,       // reduced drive bits
   input wire [W-1:0] pe_i,        // pull enable bits
   input wire [W-1:0] ps_i,        // pull select bits
   input wire [W-1:0] od_i,        // open-drain bits
   input wire [W-1:0] ie_i,        // interrupt enable bits
   input wire [W-1:0] pin_i,       // raw pin levels
   output reg [W-1:0] pin_o,       // pin output level
   output reg [W-1:0] pin_oe_o,    // pin output enable
   output reg [W-1:0] low_drive_o, // reduced strength select
   output reg [W-1:0] pull_up_o,   // pull-up enable
   output reg [W-1:0] pull_dn_o,   // pull-down enable
   output reg [W-1:0] sync_o,      // synchronised pin levels
   output wire [W-1:0] edge_o      // pin event, one-cycle pulse
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] prev_reg;
   genvar i;

   generate
      for (i = 0; i < W; i = i + 1) begin : g_pin
         // driver, strength and pull terms of one pin, registered
         always @(posedge clk_i) begin
            if (!rst_n_i) begin
               pin_o[i] <= 1'b0;
               pin_oe_o[i] <= 1'b0;
               low_drive_o[i] <= 1'b0;
               pull_up_o[i] <= 1'b0;
               pull_dn_o[i] <= 1'b0;
            end else if (ce_i) begin
               // open drain never drives high, it only releases the pin
               pin_o[i] <= val_i[i] & ~od_i[i];
               pin_oe_o[i] <= dir_i[i] & ~(od_i[i] & val_i[i]);
               low_drive_o[i] <= dir_i[i] & rdr_i[i];
               pull_up_o[i] <= pe_i[i] & ~ps_i[i] & (~dir_i[i] | od_i[i]);
               pull_dn_o[i] <= pe_i[i] & ps_i[i] & ~dir_i[i];
            end
         end
         // pull select picks the edge only where an enable exists
         if (HAS_IE != 0) begin : g_ie
            assign edge_o[i] = ie_i[i] & (ps_i[i] ? (sync_o[i] & ~prev_reg[i]) :
                                                   (~sync_o[i] & prev_reg[i]));
         end else begin : g_any
            assign edge_o[i] = sync_o[i] ^ prev_reg[i];
         end
      end
   endgenerate

   // two-stage synchroniser; only the second stage is read anywhere
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_reg <= {W{1'b0}};
         sync_o <= {W{1'b0}};
         prev_reg <= {W{1'b0}};
      end else if (ce_i) begin
         meta_reg <= pin_i;
         sync_o <= meta_reg;
         prev_reg <= sync_o;
      end
   end
endmodule // tspc_pin_port

// *** design/tspc_top.v ***
// timer port and serial port pin control with an AXI4-Lite register slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "tspc_defines.vh"

module tspc_top (
   input wire CLK_I,                 // bus clock, 100 MHz
   input wire RST_N_I,               // synchronous reset, active low
   input wire CE_I,                  // clock enable, freezes state when low
   input wire [7:0] S_AXI_AWADDR_I,  // write address
   input wire S_AXI_AWVALID_I,       // write address valid
   output reg S_AXI_AWREADY_O,       // write address ready
   input wire [31:0] S_AXI_WDATA_I,  // write data
   input wire [3:0] S_AXI_WSTRB_I,   // write strobes
   input wire S_AXI_WVALID_I,        // write data valid
   output reg S_AXI_WREADY_O,        // write data ready
   output reg [1:0] S_AXI_BRESP_O,   // write response
   output reg S_AXI_BVALID_O,        // write response valid
   input wire S_AXI_BREADY_I,        // write response ready
   input wire [7:0] S_AXI_ARADDR_I,  // read address
   input wire S_AXI_ARVALID_I,       // read address valid
   output reg S_AXI_ARREADY_O,       // read address ready
   output reg [31:0] S_AXI_RDATA_O,  // read data
   output reg [1:0] S_AXI_RRESP_O,   // read response
   output reg S_AXI_RVALID_O,        // read data valid
   input wire S_AXI_RREADY_I,        // read data ready
   output reg IRQ_O,                 // level interrupt
   input wire [7:0] TPORT_PIN_I,     // timer port pin levels
   output wire [7:0] TPORT_PIN_O,    // timer port pin drive value
   output wire [7:0] TPORT_PIN_OE_O, // timer port output enables
   output wire [7:0] TPORT_LOW_DRIVE_O, // timer port reduced drive
   output wire [7:0] TPORT_PULL_UP_O,   // timer port pull-ups
   output wire [7:0] TPORT_PULL_DN_O,   // timer port pull-downs
   input wire [7:0] TIMER_OC_EN_I,   // output compare enables
   input wire [7:0] TIMER_OC_VAL_I,  // output compare levels
   output wire [7:0] TIMER_CAPTURE_O, // synchronised pins to capture
   input wire [7:0] SPORT_PIN_I,     // serial port pin levels
   output wire [7:0] SPORT_PIN_O,    // serial port pin drive value
   output wire [7:0] SPORT_PIN_OE_O, // serial port output enables
   output wire [7:0] SPORT_LOW_DRIVE_O, // serial port reduced drive
   output wire [7:0] SPORT_PULL_UP_O,   // serial port pull-ups
   output wire [7:0] SPORT_PULL_DN_O,   // serial port pull-downs
   input wire SPI_EN_I,              // synchronous serial unit enabled
   input wire [3:0] SPI_OE_I,        // its direction for pins 7:4
   input wire [3:0] SPI_OUT_I,       // its output levels for pins 7:4
   output wire [3:0] SPI_IN_O,       // synchronised pins 7:4
   input wire [1:0] SCI_TX_EN_I,     // async tx enables, ch1 pin3, ch0 pin1
   input wire [1:0] SCI_TXD_I,       // async tx levels
   input wire [1:0] SCI_RX_EN_I,     // async rx enables, ch1 pin2, ch0 pin0
   output wire [1:0] SCI_RXD_O       // synchronised rx pins
);
   reg [7:0] tport_output_value_reg;
   reg [7:0] tport_direction_reg;
   reg [7:0] tport_drive_strength_reg;
   reg [7:0] tport_pull_enable_reg;
   reg [7:0] tport_pull_polarity_reg;
   reg [7:0] sport_output_value_reg;
   reg [7:0] sport_direction_reg;
   reg [7:0] sport_drive_strength_reg;
   reg [7:0] sport_pull_enable_reg;
   reg [7:0] sport_pull_polarity_reg;
   reg [7:0] sport_open_drain_reg;
   reg [1:0] irq_status_reg;
   reg [1:0] irq_mask_reg;
   reg aw_have_reg;
   reg w_have_reg;
   reg [5:0] aw_idx_reg;
   reg [7:0] w_data_reg;
   reg w_lane_reg;
   reg [7:0] rd_byte;
   reg rd_ok;
   reg [7:0] t_dir;
   reg [7:0] t_val;
   reg [7:0] s_dir;
   reg [7:0] s_val;
   reg [1:0] irq_status_next;
   wire [7:0] t_sync;
   wire [7:0] s_sync;
   wire [7:0] t_edge;
   wire [7:0] s_edge;
   wire aw_go;
   wire w_go;
   wire do_write;
   wire [5:0] ar_idx;
   wire wr_ok;

   // timer port: output compare takes the pin without touching the stored direction
   always @* begin
      t_dir = TIMER_OC_EN_I | tport_direction_reg;
      t_val = (TIMER_OC_EN_I & TIMER_OC_VAL_I) |
              (~TIMER_OC_EN_I & tport_output_value_reg);
   end

   // serial port: the synchronous unit, then the async channels, override direction
   always @* begin
      s_dir = sport_direction_reg;
      s_val = sport_output_value_reg;
      if (SPI_EN_I) begin
         s_dir[7:4] = SPI_OE_I;
         s_val[7:4] = SPI_OUT_I;
      end
      // tx/rx own pins 3:0
      if (SCI_TX_EN_I[1]) begin
         s_dir[3] = 1'b1;
         s_val[3] = SCI_TXD_I[1];
      end
      if (SCI_TX_EN_I[0]) begin
         s_dir[1] = 1'b1;
         s_val[1] = SCI_TXD_I[0];
      end
      if (SCI_RX_EN_I[1]) begin
         s_dir[2] = 1'b0;
      end
      if (SCI_RX_EN_I[0]) begin
         s_dir[0] = 1'b0;
      end
   end

   // timer port pins; no open drain and no interrupt enable on this port
   tspc_pin_port #(.W(8), .HAS_IE(0)) u_tport (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .dir_i(t_dir),
      .val_i(t_val),
      .rdr_i(tport_drive_strength_reg),
      .pe_i(tport_pull_enable_reg),
      .ps_i(tport_pull_polarity_reg),
      .od_i(8'h00),
      .ie_i(8'h00),
      .pin_i(TPORT_PIN_I),
      .pin_o(TPORT_PIN_O),
      .pin_oe_o(TPORT_PIN_OE_O),
      .low_drive_o(TPORT_LOW_DRIVE_O),
      .pull_up_o(TPORT_PULL_UP_O),
      .pull_dn_o(TPORT_PULL_DN_O),
      .sync_o(t_sync),
      .edge_o(t_edge)
   );

   // serial port pins; open drain also covers the peripheral outputs
   tspc_pin_port #(.W(8), .HAS_IE(0)) u_sport (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .dir_i(s_dir),
      .val_i(s_val),
      .rdr_i(sport_drive_strength_reg),
      .pe_i(sport_pull_enable_reg),
      .ps_i(sport_pull_polarity_reg),
      .od_i(sport_open_drain_reg),
      .ie_i(8'h00),
      .pin_i(SPORT_PIN_I),
      .pin_o(SPORT_PIN_O),
      .pin_oe_o(SPORT_PIN_OE_O),
      .low_drive_o(SPORT_LOW_DRIVE_O),
      .pull_up_o(SPORT_PULL_UP_O),
      .pull_dn_o(SPORT_PULL_DN_O),
      .sync_o(s_sync),
      .edge_o(s_edge)
   );

   // peripherals read the synchronised pins whatever the direction
   assign TIMER_CAPTURE_O = t_sync;
   assign SPI_IN_O = s_sync[7:4];
   assign SCI_RXD_O = {s_sync[2], s_sync[0]};

   // write channel handshakes; address and data may come in either order
   assign aw_go = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
   assign w_go = S_AXI_WVALID_I & S_AXI_WREADY_O;
   assign do_write = aw_have_reg & w_have_reg & ~S_AXI_BVALID_O;
   // bits 1:0 are ignored
   assign ar_idx = S_AXI_ARADDR_I[`TSPC_IDX_MSB:`TSPC_IDX_LSB];

   // write decode; readback indices are mapped but take no data
   assign wr_ok = (aw_idx_reg <= `TSPC_IDX_TPORT_PULL_POLARITY) ||
                  ((aw_idx_reg >= `TSPC_IDX_SPORT_OUTPUT_VALUE) &&
                   (aw_idx_reg <= `TSPC_IDX_SPORT_OPEN_DRAIN)) ||
                  (aw_idx_reg == `TSPC_IDX_IRQ_STATUS) ||
                  (aw_idx_reg == `TSPC_IDX_IRQ_MASK);

   // write address, data and response sequencing
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_idx_reg <= 6'h00;
         w_data_reg <= 8'h00;
         w_lane_reg <= 1'b0;
         S_AXI_AWREADY_O <= 1'b0;
         S_AXI_WREADY_O <= 1'b0;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= `TSPC_RESP_OKAY;
      end else if (CE_I) begin
         if (aw_go) begin
            aw_have_reg <= 1'b1;
            aw_idx_reg <= S_AXI_AWADDR_I[`TSPC_IDX_MSB:`TSPC_IDX_LSB];
         end
         if (w_go) begin
            w_have_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA_I[7:0];
            w_lane_reg <= S_AXI_WSTRB_I[0];
         end
         // ready drops the cycle a beat is taken and returns after the response
         S_AXI_AWREADY_O <= ~aw_have_reg & ~aw_go & ~S_AXI_BVALID_O & ~do_write;
         S_AXI_WREADY_O <= ~w_have_reg & ~w_go & ~S_AXI_BVALID_O & ~do_write;
         if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= wr_ok ? `TSPC_RESP_OKAY : `TSPC_RESP_SLVERR;
         end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
         end
      end
   end

   // configuration registers; only byte lane 0 carries data
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         tport_output_value_reg <= `TSPC_RST_ZERO8;
         tport_direction_reg <= `TSPC_RST_ZERO8;
         tport_drive_strength_reg <= `TSPC_RST_ZERO8;
         tport_pull_enable_reg <= `TSPC_RST_ZERO8;
         tport_pull_polarity_reg <= `TSPC_RST_ZERO8;
         sport_output_value_reg <= `TSPC_RST_ZERO8;
         sport_direction_reg <= `TSPC_RST_ZERO8;
         sport_drive_strength_reg <= `TSPC_RST_ZERO8;
         sport_pull_enable_reg <= `TSPC_RST_SPORT_PULLEN;
         sport_pull_polarity_reg <= `TSPC_RST_ZERO8;
         sport_open_drain_reg <= `TSPC_RST_ZERO8;
         irq_mask_reg <= `TSPC_RST_IRQ;
      end else if (CE_I && do_write && w_lane_reg) begin
         case (aw_idx_reg)
            `TSPC_IDX_TPORT_OUTPUT_VALUE: tport_output_value_reg <= w_data_reg;
            `TSPC_IDX_TPORT_DIRECTION: tport_direction_reg <= w_data_reg;
            `TSPC_IDX_TPORT_DRIVE_STRENGTH: tport_drive_strength_reg <= w_data_reg;
            `TSPC_IDX_TPORT_PULL_ENABLE: tport_pull_enable_reg <= w_data_reg;
            `TSPC_IDX_TPORT_PULL_POLARITY: tport_pull_polarity_reg <= w_data_reg;
            `TSPC_IDX_SPORT_OUTPUT_VALUE: sport_output_value_reg <= w_data_reg;
            `TSPC_IDX_SPORT_DIRECTION: sport_direction_reg <= w_data_reg;
            `TSPC_IDX_SPORT_DRIVE_STRENGTH: sport_drive_strength_reg <= w_data_reg;
            `TSPC_IDX_SPORT_PULL_ENABLE: sport_pull_enable_reg <= w_data_reg;
            `TSPC_IDX_SPORT_PULL_POLARITY: sport_pull_polarity_reg <= w_data_reg;
            `TSPC_IDX_SPORT_OPEN_DRAIN: sport_open_drain_reg <= w_data_reg;
            `TSPC_IDX_IRQ_MASK: irq_mask_reg <= w_data_reg[1:0];
            default: irq_mask_reg <= irq_mask_reg; // readback and status: no store
         endcase
      end
   end

   // sticky pin-change status; a new event beats a same-cycle clear
   always @* begin
      irq_status_next = irq_status_reg;
      if (do_write && w_lane_reg && (aw_idx_reg == `TSPC_IDX_IRQ_STATUS)) begin
         irq_status_next = irq_status_reg & ~w_data_reg[1:0];
      end
      irq_status_next[`TSPC_IRQ_TPORT_BIT] = irq_status_next[`TSPC_IRQ_TPORT_BIT] | (|t_edge);
      irq_status_next[`TSPC_IRQ_SPORT_BIT] = irq_status_next[`TSPC_IRQ_SPORT_BIT] | (|s_edge);
   end

   // status register and the masked interrupt level
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         irq_status_reg <= `TSPC_RST_IRQ;
         IRQ_O <= 1'b0;
      end else if (CE_I) begin
         irq_status_reg <= irq_status_next;
         // new mask acts an edge later
         IRQ_O <= |(irq_status_next & irq_mask_reg);
      end
   end

   // read mux; pin values come only from the synchroniser outputs
   always @* begin
      rd_byte = 8'h00;
      rd_ok = 1'b1;
      case (ar_idx)
         `TSPC_IDX_TPORT_OUTPUT_VALUE: rd_byte = (tport_direction_reg & tport_output_value_reg) |
                                                 (~tport_direction_reg & t_sync);
         `TSPC_IDX_TPORT_PIN_READBACK: rd_byte = t_sync;
         `TSPC_IDX_TPORT_DIRECTION: rd_byte = tport_direction_reg;
         `TSPC_IDX_TPORT_DRIVE_STRENGTH: rd_byte = tport_drive_strength_reg;
         `TSPC_IDX_TPORT_PULL_ENABLE: rd_byte = tport_pull_enable_reg;
         `TSPC_IDX_TPORT_PULL_POLARITY: rd_byte = tport_pull_polarity_reg;
         `TSPC_IDX_SPORT_OUTPUT_VALUE: rd_byte = (sport_direction_reg & sport_output_value_reg) |
                                                 (~sport_direction_reg & s_sync);
         `TSPC_IDX_SPORT_PIN_READBACK: rd_byte = s_sync;
         `TSPC_IDX_SPORT_DIRECTION: rd_byte = sport_direction_reg;
         `TSPC_IDX_SPORT_DRIVE_STRENGTH: rd_byte = sport_drive_strength_reg;
         `TSPC_IDX_SPORT_PULL_ENABLE: rd_byte = sport_pull_enable_reg;
         `TSPC_IDX_SPORT_PULL_POLARITY: rd_byte = sport_pull_polarity_reg;
         `TSPC_IDX_SPORT_OPEN_DRAIN: rd_byte = sport_open_drain_reg;
         `TSPC_IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status_reg};
         `TSPC_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
         default: rd_ok = 1'b0;
      endcase
   end

   // read channel: one read at a time, data held until taken
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h00000000;
         S_AXI_RRESP_O <= `TSPC_RESP_OKAY;
      end else if (CE_I) begin
         if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O <= {24'h000000, rd_byte};
            S_AXI_RRESP_O <= rd_ok ? `TSPC_RESP_OKAY : `TSPC_RESP_SLVERR;
         end else if (S_AXI_RVALID_O) begin
            if (S_AXI_RREADY_I) begin
               S_AXI_RVALID_O <= 1'b0;
            end
         end else begin
            // one idle cycle first
            S_AXI_ARREADY_O <= 1'b1;
         end
      end
   end
endmodule // tspc_top

// *** test/tspc_pin_model.sv ***
// far-side pin model: pad driver, pulls, external drive and floating level
`timescale 1ns/100ps
module tspc_pin_model (
   input wire clk_i,             // bus clock
   input wire [7:0] drv_i,       // pad drive value
   input wire [7:0] oe_i,        // pad output enable
   input wire [7:0] pu_i,        // pull-up enable
   input wire [7:0] pd_i,        // pull-down enable
   input wire [7:0] ext_en_i,    // external source drives the pin
   input wire [7:0] ext_val_i,   // external source level
   output logic [7:0] lvl_o      // resulting pin level
);
   logic [7:0] flt_reg = 8'h55;
   // an undriven pad toggles so a stale level never passes for a real one
   always @(posedge clk_i) flt_reg <= ~flt_reg;
   // a short from outside beats the pad, so overloaded outputs can be seen
   always @* begin
      for (int i = 0; i < 8; i++) begin
         if (ext_en_i[i]) lvl_o[i] = ext_val_i[i];
         else if (oe_i[i]) lvl_o[i] = drv_i[i];
         else if (pu_i[i]) lvl_o[i] = 1'b1;
         else if (pd_i[i]) lvl_o[i] = 1'b0;
         else lvl_o[i] = flt_reg[i];
      end
   end
endmodule // tspc_pin_model

// *** test/tspc_top_sva.sv ***
// assertion checker on the ports of the pin control top
`timescale 1ns/100ps
module tspc_top_sva (
   input wire CLK_I, RST_N_I, SPI_EN_I,
   input wire [1:0] SCI_TX_EN_I, SCI_TXD_I, SCI_RX_EN_I,
   input wire [3:0] SPI_OE_I,
   input wire [7:0] TPORT_PIN_I, TPORT_PIN_O, TPORT_PIN_OE_O, TPORT_PULL_UP_O, TPORT_PULL_DN_O,
   input wire [7:0] TIMER_OC_EN_I, TIMER_OC_VAL_I, TIMER_CAPTURE_O,
   input wire [7:0] SPORT_PIN_O, SPORT_PIN_OE_O, SPORT_PULL_UP_O, SPORT_PULL_DN_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   logic [1:0] rcnt_reg;
   // cycles since reset release; the sync chain holds reset values before that
   always @(posedge CLK_I)
      if (!RST_N_I) rcnt_reg <= 2'h0;
      else if (rcnt_reg != 2'h3) rcnt_reg <= rcnt_reg + 2'h1;
   property p_tport_out_nopull;
      ((TPORT_PULL_UP_O | TPORT_PULL_DN_O) & TPORT_PIN_OE_O) == 8'h00;
   endproperty
   a_tport_out_nopull: assert property (p_tport_out_nopull)
      else $error("pull active on a driven timer pin");
   property p_sport_dn_input;
      (SPORT_PULL_DN_O & SPORT_PIN_OE_O) == 8'h00;
   endproperty
   a_sport_dn_input: assert property (p_sport_dn_input)
      else $error("pull-down on a driven serial pin");
   property p_oc_force;
      |TIMER_OC_EN_I |=> ((TPORT_PIN_OE_O & $past(TIMER_OC_EN_I)) == $past(TIMER_OC_EN_I))
         && (((TPORT_PIN_O ^ $past(TIMER_OC_VAL_I)) & $past(TIMER_OC_EN_I)) == 8'h00);
   endproperty
   a_oc_force: assert property (p_oc_force)
      else $error("output compare did not drive its pin");
   property p_capture;
      rcnt_reg == 2'h3 |-> TIMER_CAPTURE_O == $past(TPORT_PIN_I, 2);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture path does not follow the pin");
   property p_tx_force;
      SCI_TX_EN_I[1] && !SCI_TXD_I[1] |=> SPORT_PIN_OE_O[3] && !SPORT_PIN_O[3];
   endproperty
   a_tx_force: assert property (p_tx_force)
      else $error("async transmit pin not driven low");
   property p_rx_input;
      SCI_RX_EN_I[0] |=> !SPORT_PIN_OE_O[0];
   endproperty
   a_rx_input: assert property (p_rx_input)
      else $error("async receive pin driven");
   property p_spi_dir;
      SPI_EN_I |=> (SPORT_PIN_OE_O[7:4] & ~$past(SPI_OE_I)) == 4'h0;
   endproperty
   a_spi_dir: assert property (p_spi_dir)
      else $error("serial pin driven against the sync unit direction");
   property p_rst_pulls;
      $rose(RST_N_I) |-> ##[1:2] (SPORT_PULL_UP_O == 8'hFF)
         && ((TPORT_PULL_UP_O | TPORT_PULL_DN_O) == 8'h00);
   endproperty
   a_rst_pulls: assert property (p_rst_pulls)
      else $error("pull devices wrong after reset");
endmodule // tspc_top_sva
bind tspc_top tspc_top_sva u_sva (.*);

// *** test/testbench.sv ***
// self-checking bench for the timer/serial pin control block
`timescale 1ns/100ps
`include "tspc_defines.vh"
module testbench;
   localparam logic [1:0] OK = `TSPC_RESP_OKAY;
   localparam logic [1:0] ERR = `TSPC_RESP_SLVERR;
   logic CLK_I = 1'b0, RST_N_I = 1'b0, CE_I = 1'b1, SPI_EN_I = 1'b0;
   logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
   logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0;
   logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00;
   logic [31:0] S_AXI_WDATA_I = 32'h0, rnd = 32'h3FF9;
   logic [3:0] S_AXI_WSTRB_I = 4'hF, SPI_OE_I = 4'h0, SPI_OUT_I = 4'h0;
   logic [7:0] TIMER_OC_EN_I = 8'h00, TIMER_OC_VAL_I = 8'h00, t_ext_en = 8'h00, t_ext_val = 8'h00;
   logic [1:0] SCI_TX_EN_I = 2'h0, SCI_TXD_I = 2'h0, SCI_RX_EN_I = 2'h0;
   wire S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O, IRQ_O;
   wire [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, SCI_RXD_O;
   wire [31:0] S_AXI_RDATA_O;
   wire [3:0] SPI_IN_O;
   wire [7:0] TPORT_PIN_I, TPORT_PIN_O, TPORT_PIN_OE_O, TPORT_LOW_DRIVE_O, TPORT_PULL_UP_O;
   wire [7:0] TPORT_PULL_DN_O, TIMER_CAPTURE_O, SPORT_PIN_I, SPORT_PIN_O, SPORT_PIN_OE_O;
   wire [7:0] SPORT_LOW_DRIVE_O, SPORT_PULL_UP_O, SPORT_PULL_DN_O;
   logic [33:0] exp_q[$];
   logic [15:0] rst_tab[10] = '{16'h0800, 16'h0C00, 16'h1000, 16'h1400, 16'h2800,
                                16'h2C00, 16'h34_00, 16'h3800, 16'h30FF, 16'h4400};
   int mismatches = 0, n_checks = 0;
   tspc_top DUT (.*);
   tspc_pin_model u_tpin (.clk_i(CLK_I), .drv_i(TPORT_PIN_O), .oe_i(TPORT_PIN_OE_O),
      .pu_i(TPORT_PULL_UP_O), .pd_i(TPORT_PULL_DN_O), .ext_en_i(t_ext_en),
      .ext_val_i(t_ext_val), .lvl_o(TPORT_PIN_I));
   tspc_pin_model u_spin (.clk_i(CLK_I), .drv_i(SPORT_PIN_O), .oe_i(SPORT_PIN_OE_O),
      .pu_i(SPORT_PULL_UP_O), .pd_i(SPORT_PULL_DN_O), .ext_en_i(8'h00),
      .ext_val_i(8'h00), .lvl_o(SPORT_PIN_I));
   initial begin
      forever #5 CLK_I = ~CLK_I;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one bus transfer; the answer is checked by the monitor below
   task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      int n;
      @(posedge CLK_I);
      exp_q.push_back({r, 24'h0, w ? 8'h00 : d});
      if (w) begin
         S_AXI_AWADDR_I <= a;
         S_AXI_WDATA_I <= {24'h0, d};
         S_AXI_AWVALID_I <= 1'b1;
         S_AXI_WVALID_I <= 1'b1;
         S_AXI_BREADY_I <= 1'b1;
      end else begin
         S_AXI_ARADDR_I <= a;
         S_AXI_ARVALID_I <= 1'b1;
         S_AXI_RREADY_I <= 1'b1;
      end
      n = 0;
      do begin
         @(posedge CLK_I);
         n++;
         if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
         if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
         if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
      end while (!(w ? S_AXI_BVALID_O : S_AXI_RVALID_O) && n < 40);
      S_AXI_BREADY_I <= 1'b0;
      S_AXI_RREADY_I <= 1'b0;
      if (!(w ? S_AXI_BVALID_O : S_AXI_RVALID_O)) begin
         mismatches++;
         final_report;
      end
   endtask
   // monitor: every answer takes the oldest expectation
   always @(posedge CLK_I) begin
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) chk("bresp", exp_q.pop_front(), {S_AXI_BRESP_O, 32'h0});
      if (S_AXI_RVALID_O && S_AXI_RREADY_I) chk("rdata", exp_q.pop_front(), {S_AXI_RRESP_O, S_AXI_RDATA_O});
   end
   initial begin
      repeat (10) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      repeat (3) @(posedge CLK_I);
      chk("s_pull_up", 8'hFF, SPORT_PULL_UP_O);
      chk("t_pulls", 8'h00, TPORT_PULL_UP_O | TPORT_PULL_DN_O);
      foreach (rst_tab[i]) bus(0, rst_tab[i][15:8], rst_tab[i][7:0], OK);
      // random peripheral activity, judged by the checker
      repeat (300) begin
         @(posedge CLK_I);
         rnd = lfsr(rnd);
         {TIMER_OC_EN_I, TIMER_OC_VAL_I, SPI_OE_I, SPI_OUT_I, SPI_EN_I, SCI_TX_EN_I, SCI_TXD_I,
            SCI_RX_EN_I} <= rnd[30:0];
      end
      @(posedge CLK_I);
      {TIMER_OC_EN_I, TIMER_OC_VAL_I, SPI_OE_I, SPI_OUT_I, SPI_EN_I, SCI_TX_EN_I, SCI_TXD_I,
         SCI_RX_EN_I} <= 31'h0;
      for (int i = 0; i < 9; i++) begin
         rnd = lfsr(rnd);
         bus(1, rst_tab[i][15:8], rnd[7:0], OK);
         bus(0, rst_tab[i][15:8], rnd[7:0], OK);
      end
      bus(1, 8'h18, 8'h5A, ERR);
      bus(0, 8'h18, 8'h00, ERR);
      // timer port: latch while input, short on outputs
      bus(1, 8'h08, 8'h00, OK);
      bus(1, 8'h00, 8'h3C, OK);
      t_ext_en <= 8'hFF;
      t_ext_val <= 8'h96;
      repeat (4) @(posedge CLK_I);
      bus(0, 8'h00, 8'h96, OK);
      bus(1, 8'h08, 8'hF0, OK);
      repeat (4) @(posedge CLK_I);
      bus(0, 8'h00, 8'h36, OK);
      bus(0, 8'h04, 8'h96, OK);
      t_ext_en <= 8'h00;
      bus(1, 8'h10, 8'hFF, OK);
      bus(1, 8'h14, 8'h0F, OK);
      bus(1, 8'h0C, 8'hFF, OK);
      bus(1, 8'h04, 8'h00, OK);
      bus(0, 8'h04, 8'h30, OK);
      chk("t_oe", 8'hF0, TPORT_PIN_OE_O);
      chk("t_pin", 8'h30, TPORT_PIN_O & 8'hF0);
      chk("t_pu", 8'h00, TPORT_PULL_UP_O);
      chk("t_pd", 8'h0F, TPORT_PULL_DN_O);
      chk("t_low", 8'hF0, TPORT_LOW_DRIVE_O);
      // serial port: open drain on the low nibble
      bus(1, 8'h28, 8'hFF, OK);
      bus(1, 8'h20, 8'hA5, OK);
      bus(1, 8'h38, 8'h0F, OK);
      bus(1, 8'h30, 8'hFF, OK);
      bus(1, 8'h34, 8'h00, OK);
      repeat (2) @(posedge CLK_I);
      chk("s_oe", 8'hFA, SPORT_PIN_OE_O);
      chk("s_pin", 8'hA0, SPORT_PIN_O);
      chk("s_pu", 8'h0F, SPORT_PULL_UP_O);
      bus(1, 8'h34, 8'hFF, OK);
      bus(1, 8'h28, 8'h0F, OK);
      repeat (2) @(posedge CLK_I);
      chk("s_pd", 8'hF0, SPORT_PULL_DN_O);
      chk("s_pu", 8'h00, SPORT_PULL_UP_O);
      chk("s_oe", 8'h0A, SPORT_PIN_OE_O);
      chk("s_low", 8'h00, SPORT_LOW_DRIVE_O & 8'hF0);
      bus(0, 8'h20, 8'h05, OK);
      bus(1, 8'h34, 8'h00, OK);
      // interrupt: raise, mask, clear
      repeat (4) @(posedge CLK_I);
      chk("spi_in", 4'hF, SPI_IN_O);
      chk("rxd", 2'h3, SCI_RXD_O);
      bus(1, 8'h40, 8'h03, OK);
      bus(0, 8'h40, 8'h00, OK);
      bus(1, 8'h44, 8'h01, OK);
      chk("irq", 1'b0, IRQ_O);
      t_ext_en <= 8'h01;
      t_ext_val <= 8'h01;
      repeat (5) @(posedge CLK_I);
      chk("irq", 1'b1, IRQ_O);
      bus(0, 8'h40, 8'h01, OK);
      bus(1, 8'h44, 8'h00, OK);
      repeat (2) @(posedge CLK_I);
      chk("irq", 1'b0, IRQ_O);
      bus(1, 8'h44, 8'h01, OK);
      repeat (2) @(posedge CLK_I);
      chk("irq", 1'b1, IRQ_O);
      bus(1, 8'h40, 8'h01, OK);
      repeat (2) @(posedge CLK_I);
      chk("irq", 1'b0, IRQ_O);
      bus(0, 8'h40, 8'h00, OK);
      final_report;
   end
endmodule // testbench
